// *** hw/adac_top.sv ***
// Audio DAC output block: APB registers, 8-sample buffer, clock
// generation and interrupt flag. Assumes core_clk is the PLL clock
// and the APB master follows the usual setup and access phases.
//
// Our own choices: the address map and the APB slave port.
`timescale 1ns/1ns
module adac_top #(
  parameter int DEPTH = 8,
  parameter int ADDR_W = 10
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic isr_entry,
  output logic audio_irq,
  output logic dac_sys_clk,
  output logic bit_clock_pin,
  output logic word_select_pin,
  output logic serial_data_pin
);
  adac_ser_if sif ();

  // Register fields
  logic [7:0] ctrl_a, next_ctrl_a;
  logic audio_enable_bit, next_audio_enable_bit, sample_request_mask, next_sample_request_mask, underrun_mask, next_underrun_mask;
  logic [1:0] dup, next_dup;
  logic [4:0] clkdiv, next_clkdiv;
  logic audio_interrupt_global_enable, next_audio_interrupt_global_enable;
  // Buffer and flags
  logic [7:0] mem [DEPTH];
  logic [2:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
  logic [3:0] count, next_count;
  logic [2:0] rep, next_rep;
  logic sample_request_flag, next_sample_request_flag, underrun_flag, next_underrun_flag, busy, next_busy;
  logic gflag, next_gflag, next_irq;
  logic push, pop, data_wr, sample_request_flag_set, sample_request_flag_clr, underrun_flag_set, rise;
  // Clock generation
  logic [4:0] div_cnt, next_div_cnt;
  logic sclk, next_sclk, tick;
  // Bus
  logic access, wr_en, setup;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0] idx);
    hit = (a == ADDR_W'({idx, 2'b00}));
  endfunction

  // Last repeat index for each setting of the repeat field
  function automatic logic [2:0] rep_last(input logic [1:0] d);
    case (d)
      2'b00: rep_last = 3'd0;
      2'b01: rep_last = 3'd1;
      2'b10: rep_last = 3'd3;
      default: rep_last = 3'd5;
    endcase
  endfunction

  assign setup = psel && !penable;
  assign access = psel && penable && pready;
  assign wr_en = access && pwrite;

  // Register writes take effect at the completing access edge
  always_comb begin
    next_ctrl_a = ctrl_a;
    next_audio_enable_bit = audio_enable_bit;
    next_sample_request_mask = sample_request_mask;
    next_underrun_mask = underrun_mask;
    next_dup = dup;
    next_clkdiv = clkdiv;
    next_audio_interrupt_global_enable = audio_interrupt_global_enable;
    if (wr_en && hit(paddr, adac_pkg::IDX_CTRL_A)) begin
      next_ctrl_a = pwdata[7:0];
    end
    if (wr_en && hit(paddr, adac_pkg::IDX_CTRL_B)) begin
      next_audio_enable_bit = pwdata[adac_pkg::CB_AUDIO_ENABLE_BIT];
      next_dup = pwdata[adac_pkg::CB_DUP +: 2];
      next_underrun_mask = pwdata[adac_pkg::CB_UNDERRUN_MASK];
      next_sample_request_mask = pwdata[adac_pkg::CB_SAMPLE_REQUEST_MASK];
    end
    if (wr_en && hit(paddr, adac_pkg::IDX_CLKDIV)) begin
      next_clkdiv = pwdata[4:0];
    end
    if (wr_en && hit(paddr, adac_pkg::IDX_IEN)) begin
      next_audio_interrupt_global_enable = pwdata[adac_pkg::IEN_AUDIO_INTERRUPT_GLOBAL_ENABLE];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl_a <= adac_pkg::CTRL_A_RST;
      audio_enable_bit <= adac_pkg::CTRL_B_RST[adac_pkg::CB_AUDIO_ENABLE_BIT];
      dup <= adac_pkg::CTRL_B_RST[adac_pkg::CB_DUP +: 2];
      underrun_mask <= adac_pkg::CTRL_B_RST[adac_pkg::CB_UNDERRUN_MASK];
      sample_request_mask <= adac_pkg::CTRL_B_RST[adac_pkg::CB_SAMPLE_REQUEST_MASK];
      clkdiv <= adac_pkg::CLKDIV_RST;
      audio_interrupt_global_enable <= 1'b0;
    end else begin
      ctrl_a <= next_ctrl_a;
      audio_enable_bit <= next_audio_enable_bit;
      dup <= next_dup;
      underrun_mask <= next_underrun_mask;
      sample_request_mask <= next_sample_request_mask;
      clkdiv <= next_clkdiv;
      audio_interrupt_global_enable <= next_audio_interrupt_global_enable;
    end
  end

  // Master clock: one tick per divided period, pin toggles per tick
  always_comb begin
    tick = audio_enable_bit && (div_cnt == clkdiv);
    next_div_cnt = (!audio_enable_bit || tick) ? 5'h00 : 5'(div_cnt + 5'h01);
    next_sclk = audio_enable_bit ? (sclk ^ tick) : 1'b0;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      div_cnt <= 5'h00;
      sclk <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      sclk <= next_sclk;
    end
  end

  // Buffer: a full buffer silently drops further writes
  always_comb begin
    data_wr = wr_en && hit(paddr, adac_pkg::IDX_DATA);
    push = data_wr && !busy;
    pop = sif.take && (rep == rep_last(dup));
    next_rep = rep;
    if (sif.take) begin
      next_rep = pop ? 3'd0 : 3'(rep + 3'd1);
    end
    next_wr_ptr = push ? 3'(wr_ptr + 3'd1) : wr_ptr;
    next_rd_ptr = pop ? 3'(rd_ptr + 3'd1) : rd_ptr;
    next_count = 4'(count + {3'b000, push} - {3'b000, pop});
    next_busy = (next_count == adac_pkg::BUF_FULL);
    sample_request_flag_set = pop && !push && count == adac_pkg::SAMPLE_REQUEST_FLAG_LEVEL;
    sample_request_flag_clr = data_wr ||
               (push && !pop && count == adac_pkg::SAMPLE_REQUEST_FLAG_LEVEL);
    underrun_flag_set = pop && !push && count == 4'h1;
    // A set in the same cycle as a clear wins
    next_sample_request_flag = sample_request_flag_set || (sample_request_flag && !sample_request_flag_clr);
    next_underrun_flag = underrun_flag_set || (underrun_flag && !data_wr);
    rise = (sample_request_flag_set && !sample_request_flag && !sample_request_mask) ||
           (underrun_flag_set && !underrun_flag && !underrun_mask);
    next_gflag = rise || (gflag && !isr_entry);
    next_irq = next_gflag && audio_interrupt_global_enable;
  end

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr] <= pwdata[7:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wr_ptr <= 3'd0;
      rd_ptr <= 3'd0;
      count <= 4'h0;
      rep <= 3'd0;
      busy <= adac_pkg::STATUS_RST[adac_pkg::ST_BUSY];
      sample_request_flag <= adac_pkg::STATUS_RST[adac_pkg::ST_SAMPLE_REQUEST_FLAG];
      underrun_flag <= adac_pkg::STATUS_RST[adac_pkg::ST_UNDERRUN_FLAG];
      gflag <= 1'b0;
      audio_irq <= 1'b0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
      rep <= next_rep;
      busy <= next_busy;
      sample_request_flag <= next_sample_request_flag;
      underrun_flag <= next_underrun_flag;
      gflag <= next_gflag;
      audio_irq <= next_irq;
    end
  end

  // Serialiser feed; the bit half period in master clock half periods
  // is ratio / (2 x bits per channel)
  always_comb begin
    sif.tick = tick;
    sif.channel_frame_size_bit = ctrl_a[adac_pkg::CA_CHANNEL_FRAME_SIZE_BIT];
    sif.word_select_polarity_bit = ctrl_a[adac_pkg::CA_POL];
    sif.just = ctrl_a[adac_pkg::CA_JUST +: 5];
    sif.half_ticks = 4'((ctrl_a[adac_pkg::CA_HLR] ?
                        adac_pkg::MCLK_RATIO_HI : adac_pkg::MCLK_RATIO_LO)
                       >> (ctrl_a[adac_pkg::CA_CHANNEL_FRAME_SIZE_BIT] ? 6 : 5));
    sif.word = {mem[rd_ptr], 8'h00};
    sif.word_valid = audio_enable_bit && (count != 4'h0);
  end

  adac_serializer u_ser (
    .core_clk(core_clk),
    .rst(rst),
    .sif(sif)
  );

  // Bus answers one cycle after setup; reads have no side effects
  always_comb begin
    next_pready = setup;
    next_pslverr = 1'b0;
    next_prdata = prdata;
    if (setup) begin
      next_prdata = 32'h0000_0000;
      if (hit(paddr, adac_pkg::IDX_CTRL_A)) begin
        next_prdata[7:0] = ctrl_a;
      end else if (hit(paddr, adac_pkg::IDX_CTRL_B)) begin
        next_prdata[7:0] = {2'b00, sample_request_mask, underrun_mask, 1'b0, dup, audio_enable_bit};
      end else if (hit(paddr, adac_pkg::IDX_STATUS)) begin
        next_prdata[7:0] = {sample_request_flag, underrun_flag, busy, 5'h00};
      end else if (hit(paddr, adac_pkg::IDX_DATA)) begin
        next_prdata[7:0] = adac_pkg::DATA_RST;
      end else if (hit(paddr, adac_pkg::IDX_CLKDIV)) begin
        next_prdata[7:0] = {3'b000, clkdiv};
      end else if (hit(paddr, adac_pkg::IDX_IEN)) begin
        next_prdata[7:0] = {6'h00, gflag, audio_interrupt_global_enable};
      end else begin
        next_pslverr = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      dac_sys_clk <= 1'b0;
    end else begin
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      dac_sys_clk <= next_sclk;
    end
  end

  assign bit_clock_pin = sif.bclk;
  assign word_select_pin = sif.ws;
  assign serial_data_pin = sif.sdata;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  busy_full_a: assert property (
    busy == (count == adac_pkg::BUF_FULL))
    else $error("busy flag disagrees with buffer count");
  count_bound_a: assert property (
    count <= adac_pkg::BUF_FULL)
    else $error("buffer count above eight");
  sample_request_flag_set_a: assert property (
    pop && !push && count == 4'h4 |=> sample_request_flag && count == 4'h3)
    else $error("request flag not set on 4 to 3");
  underrun_flag_set_a: assert property (
    pop && !push && count == 4'h1 |=> underrun_flag && count == 4'h0)
    else $error("under-run flag not set on empty");
  flag_clear_a: assert property (
    data_wr && !sample_request_flag_set && !underrun_flag_set |=> !sample_request_flag && !underrun_flag)
    else $error("data write did not clear flags");
  irq_gate_a: assert property (
    !audio_interrupt_global_enable |=> !audio_irq)
    else $error("interrupt raised while globally disabled");
  isr_clear_a: assert property (
    isr_entry && !rise |=> !gflag)
    else $error("service entry did not clear global flag");
  sys_clk_off_a: assert property (
    !audio_enable_bit ##1 !audio_enable_bit |-> !dac_sys_clk)
    else $error("system clock running while disabled");
  widen_a: assert property (
    sif.word_valid |-> sif.word[7:0] == 8'h00)
    else $error("low byte of widened sample not zero");
  full_c: cover property (busy ##1 !busy);
  underrun_c: cover property (underrun_flag_set);
  irq_c: cover property (!audio_irq ##1 audio_irq);
endmodule

// *** pkg/adac_pkg.sv ***
// Constants shared by the audio DAC output block and its serialiser.
// Assumes a single core_clk domain that stands in for the PLL clock.
package adac_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CTRL_A = 8'h9a;
  localparam logic [7:0] IDX_CTRL_B = 8'h9b;
  localparam logic [7:0] IDX_STATUS = 8'h9c;
  localparam logic [7:0] IDX_DATA = 8'h9d;
  localparam logic [7:0] IDX_CLKDIV = 8'hec;
  localparam logic [7:0] IDX_IEN = 8'ha8;
  // Reset values
  localparam logic [7:0] CTRL_A_RST = 8'h08;
  localparam logic [7:0] CTRL_B_RST = 8'hb2;
  localparam logic [7:0] STATUS_RST = 8'hc0;
  localparam logic [7:0] DATA_RST = 8'hff;
  localparam logic [4:0] CLKDIV_RST = 5'h00;
  // Field positions
  localparam int CA_HLR = 0;
  localparam int CA_CHANNEL_FRAME_SIZE_BIT = 1;
  localparam int CA_POL = 2;
  localparam int CA_JUST = 3;
  localparam int CB_AUDIO_ENABLE_BIT = 0;
  localparam int CB_DUP = 1;
  localparam int CB_UNDERRUN_MASK = 4;
  localparam int CB_SAMPLE_REQUEST_MASK = 5;
  localparam int ST_BUSY = 5;
  localparam int ST_UNDERRUN_FLAG = 6;
  localparam int ST_SAMPLE_REQUEST_FLAG = 7;
  localparam int IEN_AUDIO_INTERRUPT_GLOBAL_ENABLE = 0;
  localparam int IEN_FLAG = 1;
  // Master clock periods per frame, low and high ratio
  localparam logic [8:0] MCLK_RATIO_LO = 9'h100;
  localparam logic [8:0] MCLK_RATIO_HI = 9'h180;
  // Buffer watermarks
  localparam logic [3:0] BUF_FULL = 4'h8;
  localparam logic [3:0] SAMPLE_REQUEST_FLAG_LEVEL = 4'h4;
  typedef enum logic [0:0] {
    ADAC_SER_IDLE = 1'b0,
    ADAC_SER_RUN = 1'b1
  } adac_ser_state_t;
endpackage

// *** pkg/adac_ser_if.sv ***
// Link between the buffer and control logic and the serialiser.
// Assumes both ends run on core_clk.
`timescale 1ns/1ns
interface adac_ser_if;
  logic tick;
  logic [3:0] half_ticks;
  logic channel_frame_size_bit;
  logic word_select_polarity_bit;
  logic [4:0] just;
  logic [15:0] word;
  logic word_valid;
  logic take;
  logic bclk;
  logic ws;
  logic sdata;
  modport ctl (
    output tick, half_ticks, channel_frame_size_bit, word_select_polarity_bit, just, word, word_valid,
    input take, bclk, ws, sdata
  );
  modport ser (
    input tick, half_ticks, channel_frame_size_bit, word_select_polarity_bit, just, word, word_valid,
    output take, bclk, ws, sdata
  );
endinterface

// *** hw/adac_serializer.sv ***
// Serialiser: turns 16-bit words into bit clock, word select and data.
// Assumes tick marks each master clock half period from the control side.
`timescale 1ns/1ns
module adac_serializer (
  input wire logic core_clk,
  input wire logic rst,
  adac_ser_if.ser sif
);
  adac_pkg::adac_ser_state_t state, next_state;
  logic [3:0] cnt, next_cnt;
  logic [4:0] pos, next_pos;
  logic right, next_right;
  logic [15:0] word_q, next_word;
  logic bclk, next_bclk, ws, next_ws, sdata, next_sdata;
  logic take, next_take, stop;
  logic [4:0] last_bit;

  // Bits before the start point and after the sample are zero
  function automatic logic data_bit(input logic [15:0] w,
                                    input logic [4:0] p,
                                    input logic [4:0] j);
    logic [4:0] d;
    d = p - j;
    data_bit = (p >= j && d < 5'd16) ? w[4'(5'd15 - d)] : 1'b0;
  endfunction

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_pos = pos;
    next_right = right;
    next_word = word_q;
    next_bclk = bclk;
    next_ws = ws;
    next_sdata = sdata;
    next_take = 1'b0;
    stop = 1'b0;
    last_bit = sif.channel_frame_size_bit ? 5'd31 : 5'd15;
    case (state)
      adac_pkg::ADAC_SER_IDLE: begin
        next_bclk = 1'b0;
        next_ws = ~sif.word_select_polarity_bit;
        next_sdata = 1'b0;
        if (sif.tick && sif.word_valid) begin
          next_state = adac_pkg::ADAC_SER_RUN;
          next_cnt = 4'h0;
          next_pos = 5'h00;
          next_right = 1'b0;
          next_word = sif.word;
          next_take = 1'b1;
          next_ws = sif.word_select_polarity_bit;
          next_sdata = data_bit(sif.word, 5'h00, sif.just);
        end
      end
      adac_pkg::ADAC_SER_RUN: begin
        if (sif.tick) begin
          if (cnt == 4'(sif.half_ticks - 4'h1)) begin
            next_cnt = 4'h0;
            next_bclk = ~bclk;
            // Data moves on the falling edge so the DAC samples mid-bit
            if (bclk) begin
              if (pos == last_bit) begin
                next_pos = 5'h00;
                next_right = ~right;
                if (right) begin
                  if (sif.word_valid) begin
                    next_word = sif.word;
                    next_take = 1'b1;
                  end else begin
                    stop = 1'b1;
                  end
                end
              end else begin
                next_pos = 5'(pos + 5'h01);
              end
              next_ws = next_right ? ~sif.word_select_polarity_bit : sif.word_select_polarity_bit;
              next_sdata = data_bit(next_word, next_pos, sif.just);
              if (stop) begin
                next_state = adac_pkg::ADAC_SER_IDLE;
                next_bclk = 1'b0;
                next_ws = ~sif.word_select_polarity_bit;
                next_sdata = 1'b0;
              end
            end
          end else begin
            next_cnt = 4'(cnt + 4'h1);
          end
        end
      end
      default: next_state = adac_pkg::ADAC_SER_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state <= adac_pkg::ADAC_SER_IDLE;
      cnt <= 4'h0;
      pos <= 5'h00;
      right <= 1'b0;
      word_q <= 16'h0000;
      bclk <= 1'b0;
      ws <= 1'b1;
      sdata <= 1'b0;
      take <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      pos <= next_pos;
      right <= next_right;
      word_q <= next_word;
      bclk <= next_bclk;
      ws <= next_ws;
      sdata <= next_sdata;
      take <= next_take;
    end
  end

  assign sif.take = take;
  assign sif.bclk = bclk;
  assign sif.ws = ws;
  assign sif.sdata = sdata;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  idle_clock_low_a: assert property (
    state == adac_pkg::ADAC_SER_IDLE && $past(state) ==
    adac_pkg::ADAC_SER_IDLE |-> !bclk && !sdata)
    else $error("bit clock or data active while idle");
  first_word_a: assert property (
    state == adac_pkg::ADAC_SER_IDLE && sif.tick && sif.word_valid
    |=> state == adac_pkg::ADAC_SER_RUN && take)
    else $error("first word did not start the clocks");
  left_level_a: assert property (
    state == adac_pkg::ADAC_SER_RUN && $stable(sif.word_select_polarity_bit)
    |-> ws == (right ? ~sif.word_select_polarity_bit : sif.word_select_polarity_bit))
    else $error("word select level wrong for channel");
  slot_bound_a: assert property (
    state == adac_pkg::ADAC_SER_RUN && !sif.channel_frame_size_bit |-> pos < 5'd16)
    else $error("bit position past 16-bit slot");
  // Positions outside the 16-bit word, before or after it, carry zero
  zero_pad_a: assert property (
    state == adac_pkg::ADAC_SER_RUN && $stable(pos) &&
    (pos < sif.just || {1'b0, pos} >= 6'({1'b0, sif.just} + 6'd16))
    |-> !sdata)
    else $error("pad bit not zero");
  run_start_c: cover property (
    state == adac_pkg::ADAC_SER_IDLE ##1 state == adac_pkg::ADAC_SER_RUN);
  run_stop_c: cover property (
    state == adac_pkg::ADAC_SER_RUN ##1 state == adac_pkg::ADAC_SER_IDLE);
endmodule

// *** verification/adac_dac_model.sv ***
// Behavioural audio DAC: samples data on the rising bit clock and cuts
// slots at word select changes. Assumes the pins are registered on core_clk.
`timescale 1ns/1ns
module adac_dac_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic bclk,
  input wire logic ws,
  input wire logic sdata,
  output logic [31:0] last_slot,
  output logic [5:0] last_len,
  output int slots
);
  logic bclk_q;
  logic ws_q;
  logic [31:0] sh;
  logic [5:0] cnt;
  logic [6:0] idle;
  // A stopped bit clock closes the open slot, so the last right slot counts
  always_ff @(posedge core_clk) begin
    if (rst) begin
      bclk_q <= 1'b0;
      ws_q <= 1'b0;
      sh <= '0;
      cnt <= '0;
      idle <= '0;
      last_slot <= '0;
      last_len <= '0;
      slots <= 0;
    end else begin
      bclk_q <= bclk;
      if (bclk && !bclk_q) begin
        idle <= '0;
        ws_q <= ws;
        if (ws != ws_q && cnt != '0) begin
          last_slot <= sh;
          last_len <= cnt;
          slots <= slots + 1;
          sh <= {31'h0, sdata};
          cnt <= 6'h01;
        end else begin
          sh <= {sh[30:0], sdata};
          cnt <= cnt + 6'h01;
        end
      end else if (idle != 7'h40) begin
        idle <= idle + 7'h01;
      end else if (cnt != '0) begin
        last_slot <= sh;
        last_len <= cnt;
        slots <= slots + 1;
        sh <= '0;
        cnt <= '0;
      end
    end
  end
endmodule

// *** verification/adac_top_tb_top.sv ***
// Testbench for the audio DAC output block: APB master tasks, a DAC
// model on the pins, two playback streams and a repeat test. Single core_clk domain.
`timescale 1ns/1ns
module adac_top_tb_top;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic isr_entry = 1'b0;
  logic [9:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata, rd, last_slot;
  logic pready, pslverr, err, audio_irq, dac_sys_clk;
  logic bit_clock_pin, word_select_pin, serial_data_pin;
  logic [5:0] last_len;
  int slots, seen, errors, tests_run;
  time t0;
  always #2 core_clk = ~core_clk;
  adac_top #(.DEPTH(8), .ADDR_W(10)) DUT (.core_clk(core_clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .isr_entry(isr_entry), .audio_irq(audio_irq),
    .dac_sys_clk(dac_sys_clk), .bit_clock_pin(bit_clock_pin),
    .word_select_pin(word_select_pin), .serial_data_pin(serial_data_pin));
  adac_dac_model dac (.core_clk(core_clk), .rst(rst), .bclk(bit_clock_pin),
    .ws(word_select_pin), .sdata(serial_data_pin), .last_slot(last_slot),
    .last_len(last_len), .slots(slots));
  task automatic finish_test;
    $display("checks %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] idx,
                     input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20)
      errors++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(rd, {24'h0, exp});
  endtask
  function automatic logic [7:0] sv(input int i);
    return 8'(8'h5a ^ (i * 8'h27));
  endfunction
  // Slot as the DAC should see it, MSB first, zero outside the word
  function automatic logic [31:0] exp_slot(input logic [7:0] s,
                                           input int nb, input int j);
    logic [15:0] w;
    logic [31:0] r;
    w = {s, 8'h00};
    r = '0;
    for (int p = 0; p < nb; p++)
      r = {r[30:0], (p >= j && p < j + 16) ? w[15 - (p - j)] : 1'b0};
    return r;
  endfunction
  task automatic wait_slot(input logic [7:0] s, input int nb, input int j);
    int n;
    n = 0;
    while (slots == seen && n < 2000) begin
      @(posedge core_clk);
      n++;
    end
    chk(32'(n >= 2000), 32'h0);
    seen = slots;
    chk(last_slot, exp_slot(s, nb, j));
    chk({26'h0, last_len}, 32'(nb));
  endtask
  task automatic half_chk(input logic word_select_polarity_bit, input int cyc);
    @(posedge bit_clock_pin);
    chk(word_select_pin, word_select_polarity_bit);
    t0 = $time;
    @(negedge bit_clock_pin);
    chk(32'(($time - t0) / 4), 32'(cyc));
  endtask
  task automatic isr_pulse;
    @(posedge core_clk);
    isr_entry <= 1'b1;
    @(posedge core_clk);
    isr_entry <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask
  initial begin
    #200000;
    errors++;
    finish_test();
  end
  initial begin
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    rdchk(adac_pkg::IDX_CTRL_A, adac_pkg::CTRL_A_RST);
    rdchk(adac_pkg::IDX_CTRL_B, 8'h32);
    rdchk(adac_pkg::IDX_STATUS, adac_pkg::STATUS_RST);
    rdchk(adac_pkg::IDX_DATA, adac_pkg::DATA_RST);
    rdchk(adac_pkg::IDX_CLKDIV, 8'h00);
    rdchk(adac_pkg::IDX_IEN, 8'h00);
    apb(1'b0, 8'h00, 8'h00);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, adac_pkg::IDX_STATUS, 8'h00);
    rdchk(adac_pkg::IDX_STATUS, 8'hc0);
    chk({bit_clock_pin, word_select_pin, dac_sys_clk}, 3'b010);
    $display("register test done");
    // Nine writes into a disabled block: the ninth finds it full
    for (int i = 0; i < 9; i++)
      apb(1'b1, adac_pkg::IDX_DATA, sv(i));
    rdchk(adac_pkg::IDX_STATUS, 8'h20);
    apb(1'b1, adac_pkg::IDX_CLKDIV, 8'h01);
    apb(1'b1, adac_pkg::IDX_IEN, 8'h01);
    apb(1'b1, adac_pkg::IDX_CTRL_A, 8'h04);
    seen = slots;
    apb(1'b1, adac_pkg::IDX_CTRL_B, 8'h01);
    @(posedge dac_sys_clk);
    t0 = $time;
    @(posedge dac_sys_clk);
    chk(32'(($time - t0) / 4), 32'd4);
    half_chk(1'b1, 16);
    for (int i = 0; i < 16; i++) begin
      wait_slot(sv(i / 2), 16, 0);
      if (i == 3)
        rdchk(adac_pkg::IDX_STATUS, 8'h00);
    end
    repeat (1200) @(posedge core_clk);
    chk(slots, seen);
    chk({bit_clock_pin, word_select_pin, serial_data_pin}, 3'b000);
    rdchk(adac_pkg::IDX_STATUS, 8'hc0);
    chk(audio_irq, 1'b1);
    isr_pulse();
    chk(audio_irq, 1'b0);
    $display("stream test 1 done");
    apb(1'b1, adac_pkg::IDX_CLKDIV, 8'h00);
    apb(1'b1, adac_pkg::IDX_CTRL_A, 8'h83);
    apb(1'b1, adac_pkg::IDX_CTRL_B, 8'h23);
    seen = slots;
    for (int i = 0; i < 4; i++)
      apb(1'b1, adac_pkg::IDX_DATA, sv(i));
    rdchk(adac_pkg::IDX_STATUS, 8'h00);
    half_chk(1'b0, 6);
    for (int i = 0; i < 16; i++) begin
      wait_slot(sv(i / 4), 32, 16);
      if (i == 9) begin
        rdchk(adac_pkg::IDX_STATUS, 8'h80);
        chk(audio_irq, 1'b0);
      end
    end
    repeat (200) @(posedge core_clk);
    rdchk(adac_pkg::IDX_STATUS, 8'hc0);
    chk(audio_irq, 1'b1);
    apb(1'b1, adac_pkg::IDX_IEN, 8'h00);
    repeat (2) @(posedge core_clk);
    chk(audio_irq, 1'b0);
    rdchk(adac_pkg::IDX_IEN, 8'h02);
    isr_pulse();
    rdchk(adac_pkg::IDX_IEN, 8'h00);
    $display("stream test 2 done");
    apb(1'b1, adac_pkg::IDX_CTRL_A, 8'h08);
    for (int d = 0; d < 4; d++) begin
      apb(1'b1, adac_pkg::IDX_CTRL_B, 8'(1 + 2 * d));
      seen = slots;
      apb(1'b1, adac_pkg::IDX_DATA, sv(d));
      for (int k = 0; k < ((d == 3) ? 12 : 2 << d); k++)
        wait_slot(sv(d), 16, 1);
      repeat (200) @(posedge core_clk);
      chk(slots, seen);
    end
    $display("repeat test done");
    finish_test();
  end
endmodule
